/* boot_loader_pkg.sv */
// Purpose: Types shared by the boot sequencer
// Assumes: Nothing
// Notes: Constants live in boot_mode_loader_defs.svh
package boot_loader_pkg;
  typedef enum logic [3:0] {
    ST_CAPTURE, ST_XIP, ST_EE_CMD, ST_EE_ADDR, ST_EE_PROBE,
    ST_EE_RETRY, ST_LOAD, ST_RUN, ST_FAIL
  } state_type;
  typedef struct packed {
    logic [4:0] setup;
    logic [4:0] access;
    logic [4:0] hold;
  } mem_timing_type;
  typedef struct packed {
    logic bank0_sel_n;
    logic read_n;
    logic [19:0] addr;
  } flash_bus_type;
  typedef struct packed {
    logic en;
    logic [31:0] addr;
    logic [7:0] data;
  } imem_write_type;
endpackage

/* boot_mode_loader.sv */
// Purpose: Boot path selection, block loading and core release after reset
// Assumes: All inputs synchronous to clock; soft_reset_req is a one-cycle pulse
// Notes: Header is dest[31:0], count[63:32], flags[79:64], bit 64 marks last block
//
// Contract
// R1: Pins 00 bypass loading and run from 16-bit external memory.
// R2: Pins 01 load from 8- or 16-bit parallel flash.
// R3: Pins 10 load over SPI as slave from an external host.
// R4: Pins 11 load from SPI EEPROM with 8, 16 or 24-bit address.
// R5: Pins captured on power-on and software reset; path chosen from captured value.
// R6: Direct execution starts at 0x2000_0000 with 16-bit packing.
// R7: External memory timing defaults to 4 setup, 15 access, 3 hold.
// R8: Flash is read through asynchronous bank 0.
// R9: EEPROM chip select is a dedicated flag output.
// R10: Probe with 1, 2, 3 zero address bytes until EEPROM answers.
// R11: EEPROM data streams into instruction memory from the lowest address.
// R12: Every block starts with a 10-byte header: count and destination.
// R13: Any number of blocks; after last, run from instruction SRAM start.
// R14: Bypass bit makes software reset jump straight to instruction memory.
// R15: Host acts as SPI master and sends header-framed blocks.
`timescale 1ns/1ps
`include "boot_mode_loader_defs.svh"
module boot_mode_loader (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Straps and reset control
  input wire logic [1:0] boot_path_select_pins,
  input wire logic flash_width16,
  input wire logic soft_reset_req,
  input wire logic soft_boot_bypass,
  // External parallel memory
  input wire logic [15:0] mem_rdata,
  output boot_loader_pkg::flash_bus_type mem_bus,
  output boot_loader_pkg::mem_timing_type mem_timing,
  // SPI master towards the EEPROM
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic eeprom_chip_select_flag,
  // SPI slave from the host
  input wire logic host_sclk,
  input wire logic host_sel_n,
  input wire logic host_mosi,
  // Instruction memory and core
  output boot_loader_pkg::imem_write_type imem_wr,
  output logic core_release,
  output logic xip_pack16,
  output logic [31:0] core_start_addr
);
  import boot_loader_pkg::*;

  state_type state, next_state;
  logic [1:0] mode;
  logic [1:0] ee_width, ee_left;
  logic restart;
  // SPI master engine
  logic spi_busy, spi_done;
  logic [3:0] spi_cnt;
  logic [7:0] spi_sh, spi_rx;
  // Flash engine
  logic [4:0] fl_cnt;
  logic [19:0] fl_addr;
  logic fl_valid, fl_hi_pend;
  logic [7:0] fl_byte, fl_hi;
  // Host slave receiver
  logic host_sclk_q, sl_valid;
  logic [2:0] sl_bits;
  logic [7:0] sl_sh, sl_byte;
  // Block parser
  logic [79:0] hdr;
  logic [3:0] hdr_idx;
  logic [31:0] pay_addr, pay_left;
  logic last_block;

  // ----------------------------------------
  // Byte sources and selection
  // ----------------------------------------
  wire in_load = state == ST_LOAD;
  wire ee_found = spi_rx != `EE_NO_DEVICE;
  wire ee_xfer = state == ST_EE_CMD || state == ST_EE_ADDR || state == ST_EE_PROBE
                 || (in_load && mode == `MODE_EEPROM);
  wire spi_start = ee_xfer && !spi_busy && !spi_done;
  wire [7:0] spi_tx = (state == ST_EE_CMD) ? `EE_READ_CMD : 8'h00;
  wire ee_valid = spi_done && (in_load || (state == ST_EE_PROBE && ee_found));
  wire src_valid = (mode == `MODE_EEPROM) ? ee_valid :   // R11
                   (mode == `MODE_FLASH) ? fl_valid && in_load :
                   (mode == `MODE_HOST) ? sl_valid && in_load : 1'b0;
  wire [7:0] src_byte = (mode == `MODE_EEPROM) ? spi_rx :
                        (mode == `MODE_FLASH) ? fl_byte : sl_byte;
  wire [79:0] next_hdr = {src_byte, hdr[79:8]};
  wire hdr_phase = hdr_idx != `HDR_LEN;
  wire hdr_last = src_valid && hdr_idx == `HDR_LEN - 4'h1;
  wire [31:0] hdr_count = next_hdr[`HDR_COUNT_LSB +: 32];
  wire hdr_final = next_hdr[`HDR_FINAL_BIT];
  wire pay_end = src_valid && !hdr_phase && pay_left == 32'h0000_0001;
  wire load_done = (hdr_last && hdr_count == 32'h0000_0000 && hdr_final)   // R13
                   || (pay_end && last_block);
  wire fl_read_end = fl_cnt == 5'(`T_SETUP + `T_ACCESS - 5'h01);
  wire fl_cycle_end = fl_cnt == 5'(`T_SETUP + `T_ACCESS + `T_HOLD - 5'h01);
  wire fl_run = in_load && mode == `MODE_FLASH;
  wire host_rise = host_sclk && !host_sclk_q && !host_sel_n;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_CAPTURE: begin
        unique case (boot_path_select_pins)   // R5
          `MODE_XIP: next_state = ST_XIP;   // R1
          `MODE_FLASH: next_state = ST_LOAD;   // R2
          `MODE_HOST: next_state = ST_LOAD;   // R3
          `MODE_EEPROM: next_state = ST_EE_CMD;   // R4
        endcase
      end
      ST_EE_CMD: if (spi_done) next_state = ST_EE_ADDR;
      ST_EE_ADDR: if (spi_done && ee_left == 2'h1) next_state = ST_EE_PROBE;
      ST_EE_PROBE: begin
        if (spi_done) begin
          if (ee_found) next_state = load_done ? ST_RUN : ST_LOAD;
          else if (ee_width == `EE_MAX_WIDTH) next_state = ST_FAIL;
          else next_state = ST_EE_RETRY;   // R10
        end
      end
      ST_EE_RETRY: next_state = ST_EE_CMD;
      ST_LOAD: if (load_done) next_state = ST_RUN;
      ST_XIP, ST_RUN, ST_FAIL: next_state = state;
    endcase
    if (soft_reset_req) begin
      next_state = soft_boot_bypass ? ST_RUN : ST_CAPTURE;   // R14
    end
  end

  assign restart = sys_rst || soft_reset_req;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_CAPTURE;
      mode <= `MODE_XIP;
      core_release <= 1'b0;
      xip_pack16 <= 1'b0;
      core_start_addr <= `IMEM_START;
      eeprom_chip_select_flag <= 1'b1;
      mem_timing <= '{`T_SETUP, `T_ACCESS, `T_HOLD};   // R7
    end else begin
      state <= next_state;
      if (state == ST_CAPTURE) mode <= boot_path_select_pins;   // R5
      core_release <= next_state == ST_RUN || next_state == ST_XIP;
      xip_pack16 <= next_state == ST_XIP;   // R6
      core_start_addr <= (next_state == ST_XIP) ? `XIP_START : `IMEM_START;   // R6
      eeprom_chip_select_flag <= !(next_state == ST_EE_CMD || next_state == ST_EE_ADDR
        || next_state == ST_EE_PROBE || (next_state == ST_LOAD && mode == `MODE_EEPROM));   // R9
    end
  end

  // Address width tried so far: one byte first, then two, then three
  always_ff @(posedge clock) begin
    if (restart) begin
      ee_width <= 2'h1;
      ee_left <= 2'h1;
    end else if (state == ST_EE_RETRY) begin
      ee_width <= ee_width + 2'h1;   // R10
      ee_left <= ee_width + 2'h1;
    end else if (state == ST_EE_ADDR && spi_done) begin
      ee_left <= ee_left - 2'h1;
    end
  end

  // ----------------------------------------
  // SPI master, mode 0, clock is half the system clock
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (restart) begin
      spi_busy <= 1'b0;
      spi_done <= 1'b0;
      spi_cnt <= 4'h0;
      spi_sh <= 8'h00;
      spi_rx <= 8'h00;
      spi_sclk <= 1'b0;
      spi_mosi <= 1'b0;
    end else begin
      spi_done <= spi_busy && spi_cnt == 4'hf;
      if (spi_start) begin
        spi_busy <= 1'b1;
        spi_cnt <= 4'h0;
        spi_sh <= spi_tx;
        spi_mosi <= spi_tx[7];
      end else if (spi_busy) begin
        spi_cnt <= spi_cnt + 4'h1;
        spi_sclk <= !spi_cnt[0];
        if (!spi_cnt[0]) begin
          spi_rx <= {spi_rx[6:0], spi_miso};
        end else begin
          spi_sh <= {spi_sh[6:0], 1'b0};
          spi_mosi <= spi_sh[6];
        end
        if (spi_cnt == 4'hf) spi_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Parallel flash reads on bank 0
  // ----------------------------------------
  // A 16-bit word yields two bytes, low byte first; the second byte is
  // emitted during the hold phase so no extra cycles are lost.
  always_ff @(posedge clock) begin
    if (restart) begin
      fl_cnt <= 5'h00;
      fl_addr <= 20'h0_0000;
      fl_valid <= 1'b0;
      fl_hi_pend <= 1'b0;
      fl_byte <= 8'h00;
      fl_hi <= 8'h00;
      mem_bus <= '{1'b1, 1'b1, 20'h0_0000};
    end else begin
      fl_valid <= 1'b0;
      fl_hi_pend <= 1'b0;
      mem_bus.bank0_sel_n <= !(fl_run && !load_done);   // R8
      mem_bus.read_n <= !(fl_run && !load_done && fl_cnt >= `T_SETUP - 5'h01
                          && fl_cnt < 5'(`T_SETUP + `T_ACCESS - 5'h01));   // R7
      mem_bus.addr <= flash_width16 ? {1'b0, fl_addr[19:1]} : fl_addr;
      if (fl_hi_pend) begin
        fl_valid <= 1'b1;
        fl_byte <= fl_hi;
      end
      if (fl_run && !load_done) begin
        fl_cnt <= fl_cycle_end ? 5'h00 : fl_cnt + 5'h01;
        if (fl_read_end) begin
          fl_valid <= 1'b1;
          fl_byte <= mem_rdata[7:0];   // R2
          fl_hi <= mem_rdata[15:8];
          fl_hi_pend <= flash_width16;
          fl_addr <= fl_addr + (flash_width16 ? 20'h0_0002 : 20'h0_0001);
        end
      end else begin
        fl_cnt <= 5'h00;
      end
    end
  end

  // ----------------------------------------
  // SPI slave receiver, host is master, MSB first
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (restart) begin
      host_sclk_q <= 1'b0;
      sl_bits <= 3'h0;
      sl_sh <= 8'h00;
      sl_byte <= 8'h00;
      sl_valid <= 1'b0;
    end else begin
      host_sclk_q <= host_sclk;
      sl_valid <= 1'b0;
      if (host_sel_n) begin
        sl_bits <= 3'h0;
      end else if (host_rise) begin
        sl_sh <= {sl_sh[6:0], host_mosi};   // R3
        sl_bits <= sl_bits + 3'h1;
        if (sl_bits == 3'h7) begin
          sl_byte <= {sl_sh[6:0], host_mosi};
          sl_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Header parsing and instruction memory writes
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (restart) begin
      hdr <= 80'h0;
      hdr_idx <= 4'h0;
      pay_addr <= `IMEM_START;
      pay_left <= 32'h0000_0000;
      last_block <= 1'b0;
      imem_wr <= '0;
    end else begin
      imem_wr.en <= 1'b0;
      if (src_valid && hdr_phase) begin
        hdr <= next_hdr;   // R12
        hdr_idx <= hdr_idx + 4'h1;
        if (hdr_last) begin
          pay_addr <= next_hdr[`HDR_DEST_LSB +: 32];
          pay_left <= hdr_count;
          last_block <= hdr_final;
          if (hdr_count == 32'h0000_0000) hdr_idx <= 4'h0;
        end
      end else if (src_valid) begin
        imem_wr <= '{1'b1, pay_addr, src_byte};   // R11
        pay_addr <= pay_addr + 32'h0000_0001;
        pay_left <= pay_left - 32'h0000_0001;
        if (pay_end) hdr_idx <= 4'h0;   // R13
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_xip_entry: assert property (@(posedge clock) disable iff (sys_rst)   // R1
    state == ST_XIP |-> core_release && xip_pack16 && core_start_addr == `XIP_START)
    else $error("direct execution not released at its start address");
  a_pin_capture: assert property (@(posedge clock) disable iff (sys_rst)   // R5
    state == ST_CAPTURE && !soft_reset_req |=> mode == $past(boot_path_select_pins))
    else $error("boot pins not captured");
  a_mode_dispatch: assert property (@(posedge clock) disable iff (sys_rst)   // R2
    state == ST_CAPTURE && !soft_reset_req && boot_path_select_pins != `MODE_XIP
    |=> state == (($past(boot_path_select_pins) == `MODE_EEPROM) ? ST_EE_CMD : ST_LOAD))
    else $error("wrong boot path chosen");
  a_bank0_read: assert property (@(posedge clock) disable iff (sys_rst)   // R8
    !mem_bus.read_n |-> !mem_bus.bank0_sel_n)
    else $error("flash read outside bank 0");
  a_flash_access: assert property (@(posedge clock) disable iff (restart)   // R7
    $fell(mem_bus.read_n) |-> ##14 !mem_bus.read_n ##1 mem_bus.read_n)
    else $error("read strobe not 15 cycles");
  a_ee_select: assert property (@(posedge clock) disable iff (sys_rst)   // R9
    spi_sclk |-> !eeprom_chip_select_flag && mode == `MODE_EEPROM)
    else $error("eeprom clocked while deselected");
  a_probe_widen: assert property (@(posedge clock) disable iff (restart)   // R10
    state == ST_EE_PROBE && spi_done && !ee_found && ee_width != `EE_MAX_WIDTH
    |=> state == ST_EE_RETRY ##1 ee_width == $past(ee_width, 2) + 2'h1)
    else $error("address width probe out of order");
  a_header_first: assert property (@(posedge clock) disable iff (sys_rst)   // R12
    imem_wr.en |-> $past(hdr_idx) == `HDR_LEN)
    else $error("payload written before header");
  a_run_start: assert property (@(posedge clock) disable iff (sys_rst)   // R13
    $rose(state == ST_RUN) |-> core_release && core_start_addr == `IMEM_START)
    else $error("run not started at instruction memory");
  a_soft_bypass: assert property (@(posedge clock) disable iff (sys_rst)   // R14
    soft_reset_req && soft_boot_bypass |=> state == ST_RUN ##1 core_release)
    else $error("bypass did not jump to instruction memory");
endmodule

/* boot_mode_loader_defs.svh */
// Purpose: Constants for the reset-time boot sequencer
// Assumes: Included by its bare name
// Notes: Header byte order is little endian
`ifndef BOOT_MODE_LOADER_DEFS_SVH
`define BOOT_MODE_LOADER_DEFS_SVH
`define MODE_XIP 2'h0
`define MODE_FLASH 2'h1
`define MODE_HOST 2'h2
`define MODE_EEPROM 2'h3
`define XIP_START 32'h2000_0000
`define IMEM_START 32'h0000_0000
`define T_SETUP 5'h04
`define T_ACCESS 5'h0f
`define T_HOLD 5'h03
`define HDR_LEN 4'ha
`define HDR_DEST_LSB 0
`define HDR_COUNT_LSB 32
`define HDR_FINAL_BIT 64
`define EE_READ_CMD 8'h03
`define EE_NO_DEVICE 8'hff
`define EE_MAX_WIDTH 2'h3
`endif

/* boot_source_model.sv */
// Purpose: Far-side model: parallel flash on bank 0 and one SPI EEPROM
// Assumes: The bench loads img and abytes before each boot
// Notes: Released data lines do not hold their last value; MISO floats high
`timescale 1ns/1ps
module boot_source_model (
  // Parallel flash
  input wire boot_loader_pkg::flash_bus_type mem_bus,
  input wire logic flash_width16,
  output logic [15:0] mem_rdata,
  // SPI EEPROM
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic eeprom_chip_select_flag,
  output logic spi_miso
);
  import boot_loader_pkg::*;
  logic [7:0] img [0:63];
  int abytes = 1;
  int bits = 0;
  logic [7:0] cmd = 8'h00;
  logic miso_q = 1'b1;
  logic addr_nz = 1'b0;
  logic [15:0] word;
  // ----------------------------------------
  // Flash
  // ----------------------------------------
  always_comb begin
    if (flash_width16) begin
      word = {img[{mem_bus.addr[4:0], 1'b1}], img[{mem_bus.addr[4:0], 1'b0}]};
    end else begin
      word = {8'h00, img[mem_bus.addr[5:0]]};
    end
  end
  // Outside a bank 0 read the bus shows a changing value, never stale data
  assign mem_rdata = (!mem_bus.bank0_sel_n && !mem_bus.read_n) ? word : ~word;
  // ----------------------------------------
  // EEPROM
  // ----------------------------------------
  always @(posedge spi_sclk or posedge eeprom_chip_select_flag) begin
    if (eeprom_chip_select_flag) begin
      bits <= 0;
      addr_nz <= 1'b0;
    end else begin
      bits <= bits + 1;
      if (bits < 8) begin
        cmd <= {cmd[6:0], spi_mosi};
      end
      // A probe with a nonzero address gets no answer
      if (bits >= 8 && bits < 8 * (abytes + 1) && spi_mosi) addr_nz <= 1'b1;
    end
  end
  // Mode 0: next bit after the falling edge; answers only a read with its own address width
  always @(negedge spi_sclk or posedge eeprom_chip_select_flag) begin
    if (eeprom_chip_select_flag || cmd != 8'h03 || addr_nz || bits < 8 * (abytes + 1)) begin
      miso_q <= 1'b1;
    end else begin
      miso_q <= img[(bits - 8 * (abytes + 1)) / 8][7 - (bits - 8 * (abytes + 1)) % 8];
    end
  end
  assign spi_miso = miso_q;
endmodule

/* test_boot_mode_loader.sv */
// Purpose: Self-checking bench for the boot sequencer
// Assumes: Image is three blocks, the middle one empty, the last flagged final
// Notes: Expected writes come from the header fields the bench itself builds
`timescale 1ns/1ps
module test_boot_mode_loader;
  import boot_loader_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] boot_path_select_pins = 2'b00;
  logic flash_width16 = 1'b0;
  logic soft_reset_req = 1'b0;
  logic soft_boot_bypass = 1'b0;
  logic host_sclk = 1'b0;
  logic host_sel_n = 1'b1;
  logic host_mosi = 1'b0;
  logic [15:0] mem_rdata;
  flash_bus_type mem_bus;
  mem_timing_type mem_timing;
  logic spi_miso;
  logic spi_sclk;
  logic spi_mosi;
  logic eeprom_chip_select_flag;
  imem_write_type imem_wr;
  logic core_release;
  logic xip_pack16;
  logic [31:0] core_start_addr;
  int mismatches = 0;
  int checked = 0;
  int probes = 0;
  logic prev_cs = 1'b1;
  logic [39:0] expq [$];
  logic [7:0] image [$];
  always #2 clock = ~clock;
  boot_mode_loader dut (.clock(clock), .sys_rst(sys_rst), .boot_path_select_pins(boot_path_select_pins),
    .flash_width16(flash_width16), .soft_reset_req(soft_reset_req), .soft_boot_bypass(soft_boot_bypass),
    .mem_rdata(mem_rdata), .mem_bus(mem_bus), .mem_timing(mem_timing), .spi_miso(spi_miso),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .eeprom_chip_select_flag(eeprom_chip_select_flag),
    .host_sclk(host_sclk), .host_sel_n(host_sel_n), .host_mosi(host_mosi), .imem_wr(imem_wr),
    .core_release(core_release), .xip_pack16(xip_pack16), .core_start_addr(core_start_addr));
  boot_source_model src (.mem_bus(mem_bus), .flash_width16(flash_width16), .mem_rdata(mem_rdata),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .eeprom_chip_select_flag(eeprom_chip_select_flag),
    .spi_miso(spi_miso));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic make_image();
    int cnt [3] = '{5, 0, 3};
    logic [31:0] dest;
    image.delete();
    expq.delete();
    for (int b = 0; b < 3; b++) begin
      // Low dest byte never 0xFF, so the first probe byte reads as a device
      dest = 32'h0000_1000 + ($urandom & 32'h0000_0efe);
      for (int i = 0; i < 4; i++) image.push_back(dest[8*i +: 8]);
      for (int i = 0; i < 4; i++) image.push_back(8'(cnt[b] >> (8 * i)));
      image.push_back(b == 2 ? 8'h01 : 8'h00);
      image.push_back(8'h00);
      for (int i = 0; i < cnt[b]; i++) begin
        image.push_back(8'($urandom));
        expq.push_back({dest + 32'(i), image[$]});
      end
    end
    for (int i = 0; i < 64; i++) src.img[i] = i < image.size() ? image[i] : 8'h5a;
  endtask
  task automatic power_on(input logic [1:0] pins);
    boot_path_select_pins = pins;
    sys_rst = 1'b1;
    ticks(20);
    sys_rst = 1'b0;
    probes = 0;
  endtask
  task automatic wait_done(input string what);
    int n;
    n = 0;
    while (core_release !== 1'b1 && n < 20000) begin
      ticks(1);
      n++;
    end
    if (n == 20000) begin
      mismatches++;
      $display("ERROR at %0t: %s timed out", $time, what);
      give_verdict();
    end
    // The last write is launched on the same edge as the release; let the watcher see it
    ticks(1);
    chk(expq.size(), 0, "writes left");
    chk(core_start_addr, 32'h0, "start address");
    $display("Test %s done", what);
  endtask
  task automatic host_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      host_mosi = b[i];
      ticks(2);
      host_sclk = 1'b1;
      ticks(2);
      host_sclk = 1'b0;
    end
  endtask
  task automatic soft_pulse(input logic bypass);
    soft_boot_bypass = bypass;
    soft_reset_req = 1'b1;
    ticks(1);
    soft_reset_req = 1'b0;
  endtask
  // ----------------------------------------
  // Watchers
  // ----------------------------------------
  always @(negedge clock) begin
    if (imem_wr.en === 1'b1) begin
      if (expq.size() == 0) begin
        chk(1, 0, "unexpected write");
      end else begin
        chk({imem_wr.addr, imem_wr.data}, expq.pop_front(), "write");
      end
    end
    if (mem_bus.read_n === 1'b0) chk(mem_bus.bank0_sel_n, 1'b0, "bank 0 select");
    if (spi_sclk === 1'b1) chk(eeprom_chip_select_flag, 1'b0, "chip select");
    if (eeprom_chip_select_flag === 1'b0 && prev_cs === 1'b1) probes++;
    prev_cs <= eeprom_chip_select_flag;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h6854_068c));
    power_on(2'b00);
    ticks(2);
    chk(core_release, 1'b1, "xip release");
    chk(core_start_addr, 32'h2000_0000, "xip start");
    chk(xip_pack16, 1'b1, "xip packing");
    chk(mem_timing, {5'h04, 5'h0f, 5'h03}, "xip timing");
    $display("Test xip done");
    for (int w = 0; w < 2; w++) begin
      make_image();
      flash_width16 = w[0];
      power_on(2'b01);
      ticks(30);
      chk(mem_timing, {5'h04, 5'h0f, 5'h03}, "flash timing");
      wait_done("flash");
    end
    make_image();
    power_on(2'b10);
    ticks(3);
    host_sel_n = 1'b0;
    foreach (image[i]) host_byte(image[i]);
    host_sel_n = 1'b1;
    wait_done("host");
    for (int n = 1; n <= 3; n++) begin
      make_image();
      src.abytes = n;
      power_on(2'b11);
      wait_done("eeprom");
      chk(probes, n, "probe count");
    end
    // No address width answers: three probes, then the loader gives up
    src.abytes = 4;
    power_on(2'b11);
    ticks(400);
    chk(probes, 3, "probes without device");
    chk(core_release, 1'b0, "no device release");
    chk(eeprom_chip_select_flag, 1'b1, "no device select");
    $display("Test no eeprom done");
    make_image();
    flash_width16 = 1'b0;
    boot_path_select_pins = 2'b01;
    soft_pulse(1'b0);
    ticks(100);
    chk(core_release, 1'b0, "soft restart");
    chk(mem_bus.bank0_sel_n, 1'b0, "soft path");
    soft_pulse(1'b1);
    chk(core_release, 1'b1, "bypass release");
    chk(core_start_addr, 32'h0, "bypass start");
    expq.delete();
    ticks(300);
    chk(core_release, 1'b1, "bypass hold");
    $display("Test soft reset done");
    give_verdict();
  end
endmodule
